/* inc/clt_defs.svh */
// Offsets, field positions and reset values for the logic tile
`ifndef CLT_DEFS_SVH
`define CLT_DEFS_SVH

// ==========================================================
// Register map
`define CLT_AW          8
`define CLT_DW          32
`define CLT_OFF_LUT0    8'h00
`define CLT_OFF_LUT1    8'h04
`define CLT_OFF_CTL0    8'h08
`define CLT_OFF_CTL1    8'h0C
`define CLT_OFF_STAT    8'h10

// ==========================================================
// Reset values and sizes
`define CLT_CFG_RST     16'h0000
`define CLT_LUT_RST     16'h0000
`define CLT_CFG_W       16
`define CLT_LUT_D       16
`define CLT_Q_RST       2'h0

// ==========================================================
// Control register fields
`define CLT_B_MODE      2:0
`define CLT_B_CARRY     4:3
`define CLT_B_LATCH     5
`define CLT_B_ASYNC     6
`define CLT_B_CLK_INV   7
`define CLT_B_CE_INV    8
`define CLT_B_INIT_INV  9
`define CLT_B_RINIT_INV 10
`define CLT_B_IV        12:11
`define CLT_B_DSEL      14:13
`define CLT_B_ARITH     15

// ==========================================================
// Table word and status fields
`define CLT_LUT_F       15:0
`define CLT_LUT_G       31:16
`define CLT_ST_Q        3:0
`define CLT_ST_COUT     5:4
`define CLT_ST_BUS      6
`define CLT_ST_WIDE     7

`endif

/* inc/clt_pkg.sv */
// Types shared by the logic tile modules
package clt_pkg;

  // ========================================================
  // Table modes and carry modes
  typedef enum logic [2:0] {
    CLT_LOGIC   = 3'b000,
    CLT_RAM16X1 = 3'b001,
    CLT_RAM16X2 = 3'b010,
    CLT_RAM32X1 = 3'b011,
    CLT_RAM16DP = 3'b100,
    CLT_SHIFT   = 3'b101
  } clt_mode_e;

  typedef enum logic [1:0] {
    CLT_CY_ARITH = 2'b00,
    CLT_CY_MULT  = 2'b01,
    CLT_CY_CASC  = 2'b10
  } clt_carry_e;

  // ========================================================
  // Slice carriers
  typedef struct packed {
    logic [3:0] f_addr;
    logic [3:0] g_addr;
    logic       byp_x;
    logic       byp_y;
    logic       clk;
    logic       ce;
    logic       init;
    logic       rinit;
    logic       we;
    logic       wd_x;
    logic       wd_y;
    logic       a5;
    logic       cin;
  } clt_slice_in_s;

  typedef struct packed {
    logic x;
    logic y;
    logic xq;
    logic yq;
    logic wide;
    logic cout;
  } clt_slice_out_s;

endpackage

/* rtl/clt_store.sv */
// Storage element pair and control polarity of one slice
`include "clt_defs.svh"

module clt_store (
  input  wire logic                  pclk,     // System clock
  input  wire logic                  presetn,  // Async reset, low
  input  wire logic [`CLT_CFG_W-1:0] cfg,      // Slice control word
  input  wire logic                  clk_in,   // Slice clock level
  input  wire logic                  ce_in,    // Clock enable
  input  wire logic                  init_in,  // Initialise
  input  wire logic                  rinit_in, // Reverse initialise
  input  wire logic [1:0]            d,        // Data, bit1 is Y
  output logic      [1:0]            q,        // Element outputs
  output logic                       edge_p    // Active edge pulse
);
  import clt_pkg::*;

  logic       clk_a;
  logic       clk_prev;
  logic       ce_a;
  logic       init_a;
  logic       rinit_a;
  logic       async_m;
  logic       latch_m;
  logic       transp;
  logic [1:0] iv;
  logic [1:0] q_r;

  // ========================================================
  // Polarity of the shared controls
  assign clk_a   = clk_in ^ cfg[`CLT_B_CLK_INV];
  assign ce_a    = ce_in ^ cfg[`CLT_B_CE_INV];
  assign init_a  = init_in ^ cfg[`CLT_B_INIT_INV];
  assign rinit_a = rinit_in ^ cfg[`CLT_B_RINIT_INV];
  assign async_m = cfg[`CLT_B_ASYNC];
  assign latch_m = cfg[`CLT_B_LATCH];
  assign iv      = cfg[`CLT_B_IV];

  // The slice clock is a routed level; its active edge is a pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_prev <= 1'b0;
    end else begin
      clk_prev <= clk_a;
    end
  end

  assign edge_p = clk_a & ~clk_prev;
  assign transp = latch_m & clk_a & ce_a;

  // ========================================================
  // Both elements share every control, so one vector holds them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_r <= `CLT_Q_RST;
    end else if (init_a && (async_m || edge_p)) begin
      q_r <= iv;
    end else if (rinit_a && (async_m || edge_p)) begin
      q_r <= ~iv;
    end else if (transp || (!latch_m && edge_p && ce_a)) begin
      q_r <= d;
    end
  end

  // Asynchronous forcing and latch transparency show at once
  always_comb begin
    if (async_m && init_a) begin
      q = iv;
    end else if (async_m && rinit_a) begin
      q = ~iv;
    end else if (transp) begin
      q = d;
    end else begin
      q = q_r;
    end
  end

endmodule // clt_store

/* rtl/clt_tile.sv */
// Configurable logic tile: two slices, wide muxes, bus drivers, APB
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`include "clt_defs.svh"

// Notes on behaviour
// - Cell: 4-input table, carry, one storage
// - Four cells in two slices of two
// - Each table usable as 16x1 RAM
// - Slice tables form 16x2, 32x1, dual-port
// - Each table usable as 16-stage shifter
// - Storage is flip-flop or transparent latch
// - Storage input: generator or direct bypass
// - Initialise forces configured state
// - Reverse initialise forces complement state
// - Initialise signals synchronous or asynchronous
// - Shared controls each have polarity inversion
// - Slice mux picks one of two tables
// - Tile mux picks one slice mux
// - Four direct feedthrough paths per tile
// - Two carry chains, two bits each
// - Cell XOR sum and multiplier AND
// - Carry path cascades wide logic
// - Two bus drivers, own data, enable low
// - Driver drives only while enable low
// - All disabled: net resolves high
// - Any driver low: net low, wired-AND
module clt_tile (
  input  wire logic                      pclk,        // Clock
  input  wire logic                      presetn,     // Reset, low
  input  wire logic                      psel,        // APB select
  input  wire logic                      penable,     // APB enable
  input  wire logic                      pwrite,      // APB write
  input  wire logic [`CLT_AW-1:0]        paddr,       // APB address
  input  wire logic [`CLT_DW-1:0]        pwdata,      // APB write data
  output logic      [`CLT_DW-1:0]        prdata,      // APB read data
  output logic                           pready,      // APB ready
  output logic                           pslverr,     // APB error
  input  clt_pkg::clt_slice_in_s  [1:0]  s_in,        // Slice inputs
  output clt_pkg::clt_slice_out_s [1:0]  s_out,       // Slice outputs
  input  wire logic                      wide_sel,    // Tile mux select
  output logic                           tile_wide,   // Tile mux out
  input  wire logic [3:0]                feed_in,     // Feedthrough in
  output logic      [3:0]                feed_out,    // Feedthrough out
  input  wire logic [1:0]                tbuf_d,      // Driver data
  input  wire logic [1:0]                tbuf_en_n,   // Driver enable
  input  wire logic                      tbus_others, // Rest of net
  output logic      [1:0]                tbuf_out,    // Driver value
  output logic      [1:0]                tbuf_oe,     // Driver active
  output logic                           tbus_level   // Resolved net
);
  import clt_pkg::*;

  logic                         wr_en;
  logic                         rd_setup;
  logic                         hit;
  logic [`CLT_DW-1:0]           rd_val;
  logic [1:0][`CLT_CFG_W-1:0]   cfg_rd;
  logic [1:0][`CLT_DW-1:0]      lut_rd;
  logic [3:0]                   st_q;
  logic [1:0]                   st_cout;

  // ==========================================================
  // APB slave: zero wait states, write takes effect in access
  assign pready   = 1'b1;
  assign wr_en    = psel & penable & pwrite;
  assign rd_setup = psel & ~penable;

  always_comb begin
    hit    = 1'b1;
    rd_val = '0;
    case (paddr)
      `CLT_OFF_LUT0: begin
        rd_val = lut_rd[0];
      end
      `CLT_OFF_LUT1: begin
        rd_val = lut_rd[1];
      end
      `CLT_OFF_CTL0: begin
        rd_val[`CLT_CFG_W-1:0] = cfg_rd[0];
      end
      `CLT_OFF_CTL1: begin
        rd_val[`CLT_CFG_W-1:0] = cfg_rd[1];
      end
      `CLT_OFF_STAT: begin
        rd_val[`CLT_ST_Q]    = st_q;
        rd_val[`CLT_ST_COUT] = st_cout;
        rd_val[`CLT_ST_BUS]  = tbus_level;
        rd_val[`CLT_ST_WIDE] = tile_wide;
        hit = ~pwrite;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // Read data is captured in the setup cycle so it comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (rd_setup) begin
      prdata <= pwrite ? '0 : rd_val;
    end
  end

  assign pslverr = psel & penable & ~hit;

  // ==========================================================
  // Slices
  for (genvar s = 0; s < 2; s++) begin : g_sl
    localparam logic [`CLT_AW-1:0] LUT_OFF =
      (s == 0) ? `CLT_OFF_LUT0 : `CLT_OFF_LUT1;
    localparam logic [`CLT_AW-1:0] CTL_OFF =
      (s == 0) ? `CLT_OFF_CTL0 : `CLT_OFF_CTL1;

    logic [`CLT_CFG_W-1:0] cfg;
    logic [`CLT_LUT_D-1:0] lut_f;
    logic [`CLT_LUT_D-1:0] lut_g;
    clt_slice_in_s         si;
    clt_mode_e             mode;
    logic [3:0]            f_wa;
    logic [3:0]            g_wa;
    logic [3:0]            g_ra;
    logic                  f_we;
    logic                  g_we;
    logic                  f_sh;
    logic                  g_sh;
    logic                  f_wd;
    logic                  g_wd;
    logic                  f_o;
    logic                  g_o;
    logic                  wsel;
    logic                  wide_s;
    logic                  gen_f;
    logic                  gen_g;
    logic                  c_mid;
    logic                  cout;
    logic                  x;
    logic                  y;
    logic [1:0]            d;
    logic [1:0]            q;
    logic                  edge_p;

    assign si   = s_in[s];
    assign mode = clt_mode_e'(cfg[`CLT_B_MODE]);

    // Control word
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cfg <= `CLT_CFG_RST;
      end else if (wr_en && paddr == CTL_OFF) begin
        cfg <= pwdata[`CLT_CFG_W-1:0];
      end
    end

    // ----------------------------------------------------------
    // Memory write decode per mode
    always_comb begin
      f_we = 1'b0;
      g_we = 1'b0;
      f_sh = 1'b0;
      g_sh = 1'b0;
      f_wa = si.f_addr;
      g_wa = si.f_addr;
      g_ra = si.g_addr;
      f_wd = si.wd_x;
      g_wd = si.wd_y;
      case (mode)
        CLT_RAM16X1: begin
          f_we = si.we;
          g_we = si.we;
          g_wa = si.g_addr;
        end
        CLT_RAM16X2: begin
          f_we = si.we;
          g_we = si.we;
          g_ra = si.f_addr;
        end
        CLT_RAM32X1: begin
          f_we = si.we & ~si.a5;
          g_we = si.we & si.a5;
          g_wd = si.wd_x;
          g_ra = si.f_addr;
        end
        CLT_RAM16DP: begin
          f_we = si.we;
          g_we = si.we;
          g_wd = si.wd_x;
        end
        CLT_SHIFT: begin
          f_sh = si.we;
          g_sh = si.we;
        end
        default: begin
          f_we = 1'b0;
        end
      endcase
    end

    // Software load wins over a tile write in the same cycle, so a
    // configuration load is never half overwritten.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        lut_f <= `CLT_LUT_RST;
        lut_g <= `CLT_LUT_RST;
      end else if (wr_en && paddr == LUT_OFF) begin
        lut_f <= pwdata[`CLT_LUT_F];
        lut_g <= pwdata[`CLT_LUT_G];
      end else if (edge_p) begin
        if (f_sh) begin
          lut_f <= {lut_f[`CLT_LUT_D-2:0], f_wd};
        end else if (f_we) begin
          lut_f[f_wa] <= f_wd;
        end
        if (g_sh) begin
          lut_g <= {lut_g[`CLT_LUT_D-2:0], g_wd};
        end else if (g_we) begin
          lut_g[g_wa] <= g_wd;
        end
      end
    end

    // ----------------------------------------------------------
    // Table reads, also the shifter taps
    assign f_o = lut_f[si.f_addr];
    assign g_o = lut_g[g_ra];

    // 32x1 mode steers the slice mux with the top address bit
    assign wsel   = (mode == CLT_RAM32X1) ? si.a5 : si.byp_x;
    assign wide_s = wsel ? g_o : f_o;

    // ----------------------------------------------------------
    // Carry: propagate when the table is one, else generate
    always_comb begin
      gen_f = si.f_addr[0];
      gen_g = si.g_addr[0];
      case (clt_carry_e'(cfg[`CLT_B_CARRY]))
        CLT_CY_MULT: begin
          gen_f = si.f_addr[0] & si.f_addr[1];
          gen_g = si.g_addr[0] & si.g_addr[1];
        end
        CLT_CY_CASC: begin
          gen_f = 1'b0;
          gen_g = 1'b0;
        end
        default: begin
          gen_f = si.f_addr[0];
        end
      endcase
    end

    assign c_mid = f_o ? si.cin : gen_f;
    assign cout  = g_o ? c_mid : gen_g;

    // Cell outputs: plain table value or full-adder sum
    assign x = cfg[`CLT_B_ARITH] ? (f_o ^ si.cin) : f_o;
    assign y = cfg[`CLT_B_ARITH] ? (g_o ^ c_mid) : g_o;

    // ----------------------------------------------------------
    // Storage elements
    assign d[0] = cfg[`CLT_B_DSEL][0] ? si.byp_x : x;
    assign d[1] = cfg[`CLT_B_DSEL][1] ? si.byp_y : y;

    clt_store u_store (
      .pclk     (pclk),
      .presetn  (presetn),
      .cfg      (cfg),
      .clk_in   (si.clk),
      .ce_in    (si.ce),
      .init_in  (si.init),
      .rinit_in (si.rinit),
      .d        (d),
      .q        (q),
      .edge_p   (edge_p)
    );

    assign s_out[s] = '{x: x, y: y, xq: q[0], yq: q[1],
                        wide: wide_s, cout: cout};
    assign cfg_rd[s]       = cfg;
    assign lut_rd[s]       = {lut_g, lut_f};
    assign st_q[2*s +: 2]  = q;
    assign st_cout[s]      = cout;
  end

  // ==========================================================
  // Tile-level mux and feedthroughs
  assign tile_wide = wide_sel ? s_out[1].wide : s_out[0].wide;
  assign feed_out  = feed_in;

  // ==========================================================
  // Bus drivers: a disabled net floats high, any low driver wins
  assign tbuf_oe    = ~tbuf_en_n;
  assign tbuf_out   = tbuf_d;
  assign tbus_level = tbus_others & (&(~tbuf_oe | tbuf_d));

endmodule // clt_tile

/* dv/clt_net_model.sv */
// Model of the other drivers that share the tile's three-state net
module clt_net_model (
  input  wire logic pclk,        // Clock
  input  wire logic presetn,     // Reset, low
  input  wire logic quiet,       // Hold all other drivers off
  output logic      tbus_others  // Wired-AND of the other drivers
);
  logic [2:0] oth_d;
  logic [2:0] oth_en_n;

  // ==========================================================
  // Other drivers wander so that the net is sometimes pulled low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oth_d    <= 3'h5;
      oth_en_n <= 3'h7;
    end else begin
      oth_d    <= {oth_d[1:0], oth_d[2] ^ oth_d[1]};
      oth_en_n <= quiet ? 3'h7 : {oth_en_n[1:0], ~oth_en_n[2]};
    end
  end

  // A released driver counts as high, so an idle net reads high
  assign tbus_others = &(oth_d | oth_en_n);
endmodule // clt_net_model

/* dv/clt_tile_assertions.sv */
// Port checker for the logic tile
module clt_tile_assertions (
  input wire logic                 pclk,        // Clock
  input wire logic                 presetn,     // Reset, low
  input wire logic                 psel,        // APB select
  input wire logic                 penable,     // APB enable
  input wire logic                 pwrite,      // APB write
  input wire logic [7:0]           paddr,       // APB address
  input wire logic [31:0]          prdata,      // APB read data
  input wire logic                 pready,      // APB ready
  input wire logic                 pslverr,     // APB error
  input clt_pkg::clt_slice_out_s [1:0] s_out,   // Slice outputs
  input wire logic                 wide_sel,    // Tile mux select
  input wire logic                 tile_wide,   // Tile mux out
  input wire logic [3:0]           feed_in,     // Feedthrough in
  input wire logic [3:0]           feed_out,    // Feedthrough out
  input wire logic [1:0]           tbuf_d,      // Driver data
  input wire logic [1:0]           tbuf_en_n,   // Driver enable
  input wire logic                 tbus_others, // Rest of net
  input wire logic [1:0]           tbuf_out,    // Driver value
  input wire logic [1:0]           tbuf_oe,     // Driver active
  input wire logic                 tbus_level   // Resolved net
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ==========================================================
  // Tile datapath
  feed_pass_a: assert property (feed_out == feed_in)
    else $error("feedthrough differs from input");
  tile_mux_a: assert property ($changed(wide_sel) |->
    tile_wide == (wide_sel ? s_out[1].wide : s_out[0].wide))
    else $error("tile mux picks wrong slice");
  drv_enable_a: assert property (tbuf_oe == ~tbuf_en_n &&
    (tbuf_out & tbuf_oe) == (tbuf_d & tbuf_oe))
    else $error("driver enable or data wrong");
  bus_idle_a: assert property ((&tbuf_en_n && tbus_others) |-> tbus_level)
    else $error("idle net not high");
  bus_wand_a: assert property ($fell(tbuf_en_n[0]) && !tbuf_d[0]
    |-> !tbus_level)
    else $error("enabled low driver not winning");
  bus_level_a: assert property (tbus_level ==
    (tbus_others & (&(tbuf_d | tbuf_en_n))))
    else $error("net resolution wrong");

  // ==========================================================
  // Register bus
  apb_ready_a: assert property ((psel && !penable) ##1 (psel && penable)
    |-> pready)
    else $error("access phase not ready");
  unmap_err_a: assert property (psel && penable && paddr > 8'h10
    |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  stat_ro_a: assert property (psel && penable && pwrite && paddr == 8'h10
    |-> pslverr)
    else $error("status write not refused");
  err_setup_a: assert property (psel && !penable |-> !pslverr)
    else $error("error outside access phase");
endmodule // clt_tile_assertions

bind clt_tile clt_tile_assertions u_clt_tile_assertions (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .s_out(s_out), .wide_sel(wide_sel),
  .tile_wide(tile_wide), .feed_in(feed_in), .feed_out(feed_out),
  .tbuf_d(tbuf_d), .tbuf_en_n(tbuf_en_n), .tbus_others(tbus_others),
  .tbuf_out(tbuf_out), .tbuf_oe(tbuf_oe), .tbus_level(tbus_level)
);

/* dv/clt_tile_tb_top.sv */
// Self-checking bench for the logic tile
module clt_tile_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import clt_pkg::*;

  logic                 pclk, presetn, psel, penable, pwrite, pready;
  logic                 pslverr, wide_sel, tile_wide, tbus_others;
  logic                 tbus_level, quiet;
  logic [7:0]           paddr;
  logic [31:0]          pwdata, prdata, rdat, mem;
  clt_slice_in_s  [1:0] s_in;
  clt_slice_out_s [1:0] s_out;
  logic [3:0]           feed_in, feed_out;
  logic [1:0]           tbuf_d, tbuf_en_n, tbuf_out, tbuf_oe, q;
  logic [15:0]          lfsr, v;
  logic                 rerr, w0;
  int                   n_errors, total_checks;

  clt_tile u_clt_tile (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .s_in, .s_out, .wide_sel,
    .tile_wide, .feed_in, .feed_out, .tbuf_d, .tbuf_en_n, .tbus_others,
    .tbuf_out, .tbuf_oe, .tbus_level);
  clt_net_model u_clt_net_model (.pclk, .presetn, .quiet, .tbus_others);

  always #20 pclk = ~pclk;

  // ==========================================================
  // Helpers
  function automatic logic [15:0] r16();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  // Carry chain of one slice: {cout, y, x} with sums shown
  function automatic logic [2:0] arith(input logic [31:0] w,
    input logic [3:0] fa, input logic [3:0] ga, input logic ci,
    input logic [1:0] m);
    logic f, g, gf, gg, cm;
    f  = w[fa];
    g  = w[16 + ga];
    gf = (m == 2'd0) ? fa[0] : (m == 2'd1) ? fa[0] & fa[1] : 1'b0;
    gg = (m == 2'd0) ? ga[0] : (m == 2'd1) ? ga[0] & ga[1] : 1'b0;
    cm = f ? ci : gf;
    return {g ? cm : gg, g ^ cm, f ^ ci};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic finish_test();
    if (n_errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d);
    int i;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      chk("pready", 32'h1, 32'h0);
      finish_test();
    end
    rdat = prdata;
    rerr = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // Active slice clock edge; storage and tables update one edge on
  task automatic sclk(input int s);
    @(posedge pclk);
    s_in[s].clk <= 1'b1;
    repeat (2) @(posedge pclk);
    s_in[s].clk <= 1'b0;
    #1;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    {pclk, presetn, psel, penable, pwrite, quiet, wide_sel} = '0;
    {paddr, pwdata, s_in, feed_in, tbuf_d} = '0;
    tbuf_en_n = 2'h3;
    lfsr = 16'h003B;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a < 16; a += 4) begin
      apb(1'b0, 8'(a), 32'h0);
      chk("reset reg", 32'h0, rdat);
    end
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, rerr});
    chk("unmapped data", 32'h0, rdat);
    apb(1'b1, 8'h10, 32'hFFFFFFFF);
    chk("status write err", 32'h1, {31'h0, rerr});
    for (int i = 0; i < 24; i++) begin
      @(posedge pclk);
      v = r16();
      {quiet, tbuf_d, tbuf_en_n, feed_in, wide_sel} <= v[9:0];
      #1;
      chk("net", {31'h0, tbus_others & (&(tbuf_d | tbuf_en_n))},
        {31'h0, tbus_level});
      chk("driver oe", 32'h3, {30'h0, tbuf_oe ^ tbuf_en_n});
      chk("driver data", {30'h0, tbuf_d}, {30'h0, tbuf_out});
      chk("feed", {28'h0, feed_in}, {28'h0, feed_out});
    end
    @(posedge pclk);
    {quiet, tbuf_en_n} <= 3'b111;
    repeat (2) @(posedge pclk);
    #1;
    chk("idle net", 32'h1, {31'h0, tbus_level});
    mem = {r16(), r16()};
    apb(1'b1, 8'h00, mem);
    for (int i = 0; i < 8; i++) begin
      @(posedge pclk);
      v = r16();
      {s_in[0].f_addr, s_in[0].g_addr} <= v[7:0];
      #1;
      chk("table", {30'h0, mem[16 + v[3:0]], mem[v[7:4]]},
        {30'h0, s_out[0].y, s_out[0].x});
    end
    apb(1'b1, 8'h00, 32'h0000FFFF);
    @(posedge pclk);
    s_in[0].byp_x <= 1'b0;
    #1;
    w0 = s_out[0].wide;
    @(posedge pclk);
    s_in[0].byp_x <= 1'b1;
    #1;
    chk("slice mux", 32'h1, {31'h0, w0 ^ s_out[0].wide});
    for (int s = 0; s < 2; s++) begin
      for (int m = 0; m < 3; m++) begin
        mem = {r16(), r16()};
        apb(1'b1, 8'(4 * s), mem);
        apb(1'b1, 8'(8 + 4 * s), 32'h8000 | (m << 3));
        for (int i = 0; i < 6; i++) begin
          @(posedge pclk);
          v = r16();
          {s_in[s].cin, s_in[s].g_addr, s_in[s].f_addr} <= v[8:0];
          #1;
          chk("carry", {29'h0, arith(mem, v[3:0], v[7:4], v[8], 2'(m))},
            {29'h0, s_out[s].cout, s_out[s].y, s_out[s].x});
        end
      end
    end
    apb(1'b1, 8'h0C, 32'h0);
    mem = {r16(), r16()};
    apb(1'b1, 8'h00, mem);
    for (int k = 0; k < 16; k++) begin
      w0 = (k % 3 == 0);
      apb(1'b1, 8'h08, (k % 3 == 1) ? 32'h2 : (w0 ? 32'h1 : 32'h4));
      @(posedge pclk);
      v = r16();
      {s_in[0].ce, s_in[0].we, s_in[0].wd_y, s_in[0].wd_x} <= {v[10], 3'(v[9:8]) | 3'h4};
      {s_in[0].g_addr, s_in[0].f_addr} <= v[7:0];
      mem[v[3:0]] = v[8];
      if (w0) mem[16 + v[7:4]] = v[9];
      else mem[16 + v[3:0]] = (k % 3 == 1) ? v[9] : v[8];
      sclk(0);
      chk("ram read", {30'h0, (k % 3 == 1) ? mem[16 + v[3:0]] :
        mem[16 + v[7:4]], mem[v[3:0]]},
        {30'h0, s_out[0].y, s_out[0].x});
    end
    apb(1'b0, 8'h00, 32'h0);
    chk("ram word", mem, rdat);
    // 32x1: top address bit picks the G half, read through the slice mux
    apb(1'b1, 8'h08, 32'h3);
    for (int i = 0; i < 4; i++) begin
      @(posedge pclk);
      v = r16();
      {s_in[0].a5, s_in[0].wd_x, s_in[0].f_addr} <= v[5:0];
      mem[{v[5], v[3:0]}] = v[4];
      sclk(0);
      chk("ram32 read", {31'h0, mem[{v[5], v[3:0]}]},
        {31'h0, s_out[0].wide});
    end
    apb(1'b1, 8'h08, 32'h5);
    for (int i = 0; i < 16; i++) begin
      @(posedge pclk);
      v = r16();
      {s_in[0].wd_y, s_in[0].wd_x} <= v[1:0];
      mem = {mem[30:16], v[1], mem[14:0], v[0]};
      sclk(0);
    end
    apb(1'b0, 8'h00, 32'h0);
    chk("shift word", mem, rdat);
    apb(1'b1, 8'h08, 32'h6800);
    for (int i = 0; i < 8; i++) begin
      q = {s_out[0].yq, s_out[0].xq};
      @(posedge pclk);
      v = r16();
      {s_in[0].ce, s_in[0].byp_y, s_in[0].byp_x} <= v[2:0];
      sclk(0);
      chk("store", {30'h0, v[2] ? v[1:0] : q},
        {30'h0, s_out[0].yq, s_out[0].xq});
    end
    @(posedge pclk);
    s_in[0].init <= 1'b1;
    sclk(0);
    chk("init", 32'h1, {30'h0, s_out[0].yq, s_out[0].xq});
    @(posedge pclk);
    {s_in[0].init, s_in[0].rinit} <= 2'b01;
    sclk(0);
    chk("rinit", 32'h2, {30'h0, s_out[0].yq, s_out[0].xq});
    @(posedge pclk);
    s_in[0].rinit <= 1'b0;
    // Latch with inverted enable: transparent while clock high, ce low
    apb(1'b1, 8'h08, 32'h6120);
    for (int i = 0; i < 4; i++) begin
      @(posedge pclk);
      v = r16();
      {s_in[0].clk, s_in[0].ce} <= 2'b10;
      {s_in[0].byp_y, s_in[0].byp_x} <= v[1:0];
      #1;
      chk("latch", {30'h0, v[1:0]},
        {30'h0, s_out[0].yq, s_out[0].xq});
    end
    @(posedge pclk);
    s_in[0].clk <= 1'b0;
    apb(1'b1, 8'h08, 32'h6A40);
    #1;
    chk("async init", 32'h1, {30'h0, s_out[0].yq, s_out[0].xq});
    finish_test();
  end
endmodule // clt_tile_tb_top
